// file: cwb_pkg.sv
`default_nettype none
package cwb_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CWB_CTRL_OFS     = 8'h00;
    localparam logic [7:0]  CWB_ISCR_OFS     = 8'h04;
    localparam logic [7:0]  CWB_FADDR_OFS    = 8'h08;
    localparam logic [7:0]  CWB_FATTR_OFS    = 8'h0c;
    localparam logic [7:0]  CWB_FDATA_OFS    = 8'h10;
    localparam logic [7:0]  CWB_IRQ_STAT_OFS = 8'h14;
    localparam logic [7:0]  CWB_IRQ_MASK_OFS = 8'h18;
    // Control register fields.
    localparam int          CWB_CTRL_WBEN_BIT  = 0;
    localparam logic        CWB_CTRL_RESET     = 1'b0;
    // Status and control fields: fault, multiple fault, irq enable.
    localparam int          CWB_ISCR_FAULT_BIT = 0;
    localparam int          CWB_ISCR_MULTI_BIT = 1;
    localparam int          CWB_ISCR_IRQEN_BIT = 8;
    // Event status bits: any buffered write faulted, bus write completed.
    localparam int          CWB_EV_FAULT_BIT   = 0;
    localparam int          CWB_EV_DONE_BIT    = 1;
    localparam int          CWB_EV_W           = 2;
    localparam logic [1:0]  CWB_HTRANS_IDLE    = 2'h0;
    localparam logic [1:0]  CWB_HTRANS_NONSEQ  = 2'h2;
    localparam logic [2:0]  CWB_HSIZE_WORD     = 3'h2;
    // Write transfer as it travels from core to system bus.
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  attr;
    } cwb_wr_s;
    typedef enum logic [1:0] {CWB_IDLE, CWB_ADDR, CWB_DATA} cwb_st_e;
endpackage
`default_nettype wire

// file: cwb_write_buffer.sv
`default_nettype none
module cwb_write_buffer
    import cwb_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Register slave.
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    // Core write port.
    input  wire logic        core_wr_req,
    input  wire cwb_wr_s     core_wr,
    input  wire logic        core_wr_buffable,
    output var  logic        core_wr_ack,
    output var  logic        core_wr_err,
    // System bus write master port.
    output var  logic        sys_wr_valid,
    output var  cwb_wr_s     sys_wr,
    input  wire logic        sys_wr_done,
    input  wire logic        sys_wr_err,
    output var  logic        irq
);
    // ------------------------------------------------------------
    // Operation notes
    // ------------------------------------------------------------
    // The register slave answers every transfer with zero wait states and an OKAY response.
    // A transfer is taken at the edge where hsel, hready and a NONSEQ htrans are all seen.
    // Read data is registered at that edge and stands for the one data-phase cycle.
    // Write data is taken at the end of the data phase, one edge after the address.
    // Unmapped offsets read as zero, and writes to them are dropped without a sign.
    // The control register holds only the buffer enable, in its lowest bit.
    // The status and control register holds the fault flag, the multiple-fault flag and the irq enable.
    // Writing a one to the fault flag position clears both flags together.
    // The irq enable bit is stored and reads back, but it never reaches the irq output.
    // That silent enable is deliberate: the silicon this block stands for behaves that way.
    // Software therefore polls the fault flag, or keeps the buffer off so faults stay precise.
    // The fault address, attribute and data registers hold the first fault only.
    // A later fault while the flag is still set is not captured; it raises the multiple-fault flag and the fault event.
    // The event status register gathers a fault event and a write-done event.
    // Reading the event status register clears it at the address edge of that read.
    // The read still returns the bits that were set before the clear.
    // An event that lands on the same edge as the clearing read survives the clear.
    // The event mask has the same layout, and irq is high while any unmasked event stands.
    // The core write port takes a request only while the single entry is free.
    // A request is also ignored in the cycle in which core_wr_ack is high.
    // That one-cycle gap lets the core drop its request before it could be taken twice.
    // A buffered write is acknowledged one cycle after it is taken.
    // The core therefore moves on while the system bus is still busy with the write.
    // A bus error on such a write never reaches the core as an error response.
    // Only the capture logic and the event status see that error.
    // An unbuffered write is acknowledged only after the system bus reports completion.
    // Its error, if any, comes back on core_wr_err together with the acknowledge.
    // Unbuffered writes keep precise faults whether or not the buffer is enabled.
    // The entry drives sys_wr_valid and sys_wr until sys_wr_done is seen.
    // The system bus may take as many cycles as it likes; nothing here times out.
    // Clearing the enable while a buffered write is pending does not recall that write.
    // The pending write still finishes and is still captured if it fails.
    // Only writes taken after the clear bypass the buffer.
    // A fault that completes on the same edge as a clearing write wins over the clear.
    // In that case the flag stays set and the new fault is captured afresh.
    // A fault that meets a non-clearing write to the same register counts as a second fault only if the flag is already set.
    // All state resets to zero, and the buffer starts disabled.
    // Every output comes from a flip-flop, apart from the two constant bus answers.
    // The transfer size input is ignored, since only whole words are mapped.
    // Byte lanes are not merged: a narrow write acts on the whole register word.
    // The attribute field is kept four bits wide, as the core presents it.
    // No second write can overtake the pending one, since the entry holds only one.
    // Reads of the capture registers have no side effect, so they can be polled freely.
    // Only the event status register has a read side effect.
    // A debugger read of that register will therefore lose pending events.
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic            wb_en, next_wb_en;
    logic            f_flag, next_f_flag;
    logic            f_multi, next_f_multi;
    logic            irq_en, next_irq_en;
    cwb_wr_s         f_cap, next_f_cap;
    logic [CWB_EV_W-1:0] ev_stat, next_ev_stat, ev_mask, next_ev_mask;
    logic            pend, next_pend;
    logic            pend_buf, next_pend_buf;
    cwb_wr_s         pend_wr, next_pend_wr;
    logic            ack, next_ack, err, next_err;
    logic            irq_q, next_irq;
    logic            dp_act, next_dp_act, dp_wr, next_dp_wr;
    logic [7:0]      dp_addr, next_dp_addr;
    logic [31:0]     rdata, next_rdata;
    logic            rd_stat_now;
    logic            wr_iscr_now;

    // ------------------------------------------------------------
    // Bus slave and register decode
    // ------------------------------------------------------------
    // Address phase is latched; writes act in the data phase; reads return next cycle.
    always_comb begin
        next_dp_act  = hsel && hready && (htrans == CWB_HTRANS_NONSEQ);
        next_dp_wr   = hwrite;
        next_dp_addr = haddr;
        next_rdata   = 32'h0000_0000;
        if (hsel && hready && (htrans == CWB_HTRANS_NONSEQ) && !hwrite) begin
            case (haddr)
                CWB_CTRL_OFS:     next_rdata[CWB_CTRL_WBEN_BIT] = wb_en;
                CWB_ISCR_OFS: begin
                    next_rdata[CWB_ISCR_FAULT_BIT] = f_flag;
                    next_rdata[CWB_ISCR_MULTI_BIT] = f_multi;
                    next_rdata[CWB_ISCR_IRQEN_BIT] = irq_en;
                end
                CWB_FADDR_OFS:    next_rdata = f_cap.addr;
                CWB_FATTR_OFS:    next_rdata = {28'h000_0000, f_cap.attr};
                CWB_FDATA_OFS:    next_rdata = f_cap.data;
                CWB_IRQ_STAT_OFS: next_rdata = {30'h0000_0000, ev_stat};
                CWB_IRQ_MASK_OFS: next_rdata = {30'h0000_0000, ev_mask};
                default:          next_rdata = 32'h0000_0000;
            endcase
        end
    end
    assign rd_stat_now = hsel && hready && (htrans == CWB_HTRANS_NONSEQ) && !hwrite
                         && (haddr == CWB_IRQ_STAT_OFS);
    assign wr_iscr_now = dp_act && dp_wr && (dp_addr == CWB_ISCR_OFS);

    // ------------------------------------------------------------
    // Write buffer and fault capture
    // ------------------------------------------------------------
    // One entry holds the write in flight; buffered ones are acked at once.
    always_comb begin
        next_wb_en   = wb_en;
        next_irq_en  = irq_en;
        next_ev_mask = ev_mask;
        next_f_flag  = f_flag;
        next_f_multi = f_multi;
        next_f_cap   = f_cap;
        next_pend    = pend;
        next_pend_buf = pend_buf;
        next_pend_wr = pend_wr;
        next_ack     = 1'b0;
        next_err     = 1'b0;
        next_ev_stat = ev_stat;
        if (rd_stat_now) begin
            next_ev_stat = '0;
        end
        if (dp_act && dp_wr && (dp_addr == CWB_CTRL_OFS)) begin
            next_wb_en = hwdata[CWB_CTRL_WBEN_BIT];
        end
        if (dp_act && dp_wr && (dp_addr == CWB_IRQ_MASK_OFS)) begin
            next_ev_mask = hwdata[CWB_EV_W-1:0];
        end
        if (wr_iscr_now) begin
            next_irq_en = hwdata[CWB_ISCR_IRQEN_BIT];
            if (hwdata[CWB_ISCR_FAULT_BIT]) begin
                next_f_flag  = 1'b0;
                next_f_multi = 1'b0;
            end
        end
        // Completion of the single pending write on the system bus.
        if (pend && sys_wr_done) begin
            next_pend = 1'b0;
            next_ev_stat[CWB_EV_DONE_BIT] = 1'b1;
            if (pend_buf) begin
                if (sys_wr_err) begin
                    next_ev_stat[CWB_EV_FAULT_BIT] = 1'b1;
                    // A clearing write on this edge makes the new fault the first one again.
                    if (f_flag && !(wr_iscr_now && hwdata[CWB_ISCR_FAULT_BIT])) begin
                        next_f_multi = 1'b1;
                    end else begin
                        next_f_cap = pend_wr;
                    end
                    next_f_flag = 1'b1;
                end
            end else begin
                next_ack = 1'b1;
                next_err = sys_wr_err; // Unbuffered writes keep precise faults.
            end
        end
        // A new write is taken only while the entry is free.
        if (core_wr_req && !pend && !ack) begin
            next_pend     = 1'b1;
            next_pend_wr  = core_wr;
            next_pend_buf = wb_en && core_wr_buffable;
            if (wb_en && core_wr_buffable) begin
                next_ack = 1'b1;
            end
        end
        // Capture works but the fault interrupt stays silent; only the event mask drives irq.
        next_irq = |(next_ev_stat & next_ev_mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Bus slave data-phase state and registered read data.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_act   <= 1'b0;
            dp_wr    <= 1'b0;
            dp_addr  <= 8'h00;
            rdata    <= 32'h0000_0000;
        end else begin
            dp_act   <= next_dp_act;
            dp_wr    <= next_dp_wr;
            dp_addr  <= next_dp_addr;
            rdata    <= next_rdata;
        end
    end

    // Control bits, sticky fault flags and the captured fault fields.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wb_en    <= CWB_CTRL_RESET;
            irq_en   <= 1'b0;
            f_flag   <= 1'b0;
            f_multi  <= 1'b0;
            f_cap    <= '0;
        end else begin
            wb_en    <= next_wb_en;
            irq_en   <= next_irq_en;
            f_flag   <= next_f_flag;
            f_multi  <= next_f_multi;
            f_cap    <= next_f_cap;
        end
    end

    // The single buffer entry and the core handshake pulses.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend     <= 1'b0;
            pend_buf <= 1'b0;
            pend_wr  <= '0;
            ack      <= 1'b0;
            err      <= 1'b0;
        end else begin
            pend     <= next_pend;
            pend_buf <= next_pend_buf;
            pend_wr  <= next_pend_wr;
            ack      <= next_ack;
            err      <= next_err;
        end
    end

    // Event status, event mask and the registered interrupt level.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ev_mask  <= '0;
            ev_stat  <= '0;
            irq_q    <= 1'b0;
        end else begin
            ev_mask  <= next_ev_mask;
            ev_stat  <= next_ev_stat;
            irq_q    <= next_irq;
        end
    end

    // Outputs, all from flip-flops apart from the constant hreadyout and hresp.
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = rdata;
    assign core_wr_ack  = ack;
    assign core_wr_err  = err;
    assign sys_wr_valid = pend;
    assign sys_wr       = pend_wr;
    assign irq          = irq_q;
endmodule
`default_nettype wire

// file: cwb_wb_props.sv
`default_nettype none
module cwb_wb_props
    import cwb_pkg::*;
(
    input wire logic    hclk,
    input wire logic    hresetn,
    input wire logic    hreadyout,
    input wire logic    hresp,
    input wire cwb_wr_s core_wr,
    input wire logic    core_wr_ack,
    input wire logic    core_wr_err,
    input wire logic    sys_wr_valid,
    input wire cwb_wr_s sys_wr,
    input wire logic    sys_wr_done,
    input wire logic    sys_wr_err
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------------------------------------------------------
    // Handshake checks
    // ------------------------------------------------------------
    // The register slave never stalls and always answers OKAY.
    a_zero_wait: assert property (hreadyout && !hresp) else $error("register slave stalled or erred");
    a_ack_pulse: assert property (core_wr_ack |=> !core_wr_ack) else $error("ack held two cycles");
    a_err_with_ack: assert property (core_wr_err |-> core_wr_ack) else $error("err without ack");
    a_err_from_bus: assert property (core_wr_err |-> $past(sys_wr_done && sys_wr_err))
        else $error("err not caused by bus");
    a_early_ack: assert property (core_wr_ack && !$past(sys_wr_done) |-> sys_wr_valid)
        else $error("buffered ack after bus end");
    a_entry_load: assert property ($rose(sys_wr_valid) |-> sys_wr == $past(core_wr))
        else $error("entry differs from request");
    a_entry_hold: assert property (sys_wr_valid && !sys_wr_done |=> sys_wr_valid && $stable(sys_wr))
        else $error("entry lost");
    a_entry_free: assert property (sys_wr_valid && sys_wr_done |=> !sys_wr_valid)
        else $error("entry kept after done");
    // Main scenarios seen.
    c_buf_ack: cover property (core_wr_ack && sys_wr_valid);
    c_precise: cover property (core_wr_err);
    c_bus_err: cover property (sys_wr_done && sys_wr_err);
endmodule
bind cwb_write_buffer cwb_wb_props u_props (.hclk, .hresetn, .hreadyout, .hresp, .core_wr, .core_wr_ack,
    .core_wr_err, .sys_wr_valid, .sys_wr, .sys_wr_done, .sys_wr_err);
`default_nettype wire

// file: cwb_bus_model.sv
`default_nettype none
module cwb_bus_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       sys_wr_valid,
    input  wire logic       fail,
    input  wire logic [1:0] lat,
    output var  logic       sys_wr_done,
    output var  logic       sys_wr_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;
    // Ends a pending write lat+1 cycles after sys_wr_valid rises; the error line toggles when not qualified.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt         <= 2'h0;
            sys_wr_done <= 1'b0;
            sys_wr_err  <= 1'b0;
        end else begin
            sys_wr_done <= sys_wr_valid && !sys_wr_done && cnt == lat;
            sys_wr_err  <= (sys_wr_valid && !sys_wr_done && cnt == lat) ? fail : !sys_wr_err;
            cnt         <= (sys_wr_valid && !sys_wr_done) ? cnt + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

// file: cwb_write_buffer_tb_top.sv
`default_nettype none
module cwb_write_buffer_tb_top;
    import cwb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
    logic [7:0]  haddr = 0;
    logic [1:0]  htrans = 0, lat = 0;
    logic [31:0] hwdata = 0, hrdata, rd;
    logic        req = 0, bufb = 0, ack, err, sv, sd, se, fail = 0, e, v;
    cwb_wr_s     wr = '0, sw;
    int          num_errors = 0, samples_checked = 0;
    always #2 hclk = ~hclk;
    cwb_write_buffer DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(CWB_HSIZE_WORD), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .core_wr_req(req), .core_wr(wr),
        .core_wr_buffable(bufb), .core_wr_ack(ack), .core_wr_err(err), .sys_wr_valid(sv), .sys_wr(sw),
        .sys_wr_done(sd), .sys_wr_err(se), .irq);
    cwb_bus_model u_bus (.hclk, .hresetn, .sys_wr_valid(sv), .fail, .lat, .sys_wr_done(sd), .sys_wr_err(se));
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    // One AHB single word transfer; read data is taken at the data phase end.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1; htrans <= CWB_HTRANS_NONSEQ; haddr <= a; hwrite <= w;
        do @(posedge hclk); while (!hreadyout);
        hsel <= 0; htrans <= CWB_HTRANS_IDLE; hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
        rd = hrdata;
    endtask
    // One core write, held until acknowledged, then waits for the bus to go idle.
    task automatic cwr(input logic [31:0] a, input logic b);
        @(posedge hclk);
        req <= 1; bufb <= b; wr <= '{addr: a, data: ~a, attr: 4'h5};
        do @(posedge hclk); while (!ack);
        e = err; v = sv; req <= 0;
        while (sv) @(posedge hclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1;
        ahb(0, CWB_CTRL_OFS, 0); chk(rd, 0);
        fail <= 1; lat <= 2'h2;
        cwr(32'h100, 1); chk({e, v}, 2'b10);
        $display("test precise done");
        ahb(1, CWB_CTRL_OFS, 1); ahb(0, CWB_CTRL_OFS, 0); chk(rd, 1);
        cwr(32'h200, 1); chk({e, v}, 2'b01);
        ahb(0, CWB_ISCR_OFS, 0); chk(rd, 1);
        ahb(0, CWB_FADDR_OFS, 0); chk(rd, 32'h200);
        ahb(0, CWB_FATTR_OFS, 0); chk(rd, 5);
        ahb(0, CWB_FDATA_OFS, 0); chk(rd, ~32'h200);
        lat <= 2'h0;
        cwr(32'h300, 1); chk({e, v}, 2'b01);
        ahb(0, CWB_ISCR_OFS, 0); chk(rd, 3);
        ahb(0, CWB_FADDR_OFS, 0); chk(rd, 32'h200);
        $display("test imprecise done");
        ahb(1, CWB_ISCR_OFS, 32'h100); @(posedge hclk); chk(irq, 0);
        ahb(1, CWB_IRQ_MASK_OFS, 1); @(posedge hclk); chk(irq, 1);
        ahb(0, CWB_IRQ_STAT_OFS, 0); chk(rd, 3);
        @(posedge hclk); chk(irq, 0);
        ahb(1, CWB_ISCR_OFS, 32'h101); ahb(0, CWB_ISCR_OFS, 0); chk(rd, 32'h100);
        ahb(0, 8'h1c, 0); chk(rd, 0);
        $display("test irq done");
        print_verdict;
    end
    // Cuts a hang short.
    initial begin
        #20000;
        num_errors++;
        print_verdict;
    end
endmodule
`default_nettype wire
